//--- tb/line_partner.sv
`timescale 1ns/1ps
`include "codec_cfg.svh"

// ==================================================
// Far-side line transceiver
module line_partner (
	input wire logic clk, // System clock
	input wire logic line_tx_clock, // Bit clock from block
	input wire logic line_tx_data, // Line level from block
	input wire logic [4:0] exp_sym, // Symbol expected after escape
	output logic match, // Escape then expected symbol seen
	output logic line_rx_clock, // Bit clock to block
	output logic line_rx_data // Line level to block
);
	logic [4:0] q[$];
	logic [4:0] sh = 5'h00;
	logic [2:0] nb = 3'h0;
	logic [1:0] ph = 2'h0;
	logic act = 1'h0;
	logic [9:0] win = 10'h000;
	logic tprev = 1'h0;

	initial begin
		line_rx_clock = 1'h0;
		line_rx_data = 1'h0;
	end

	task automatic send(input logic [4:0] s);
		q.push_back(s);
	endtask : send

	function automatic bit idle();
		return nb == 3'h0 && q.size() == 0 && !act;
	endfunction : idle

	// ==================================================
	// Receive stream: four clk per bit, still when idle
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		if (ph == 2'h1)
			line_rx_clock <= act;
		if (ph == 2'h3) begin
			line_rx_clock <= 1'h0;
			if (nb == 3'h0 && q.size() != 0) begin
				sh = q.pop_front();
				nb = 3'h5;
			end
			act = nb != 3'h0;
			if (act) begin
				// A one toggles the level, MSB first
				line_rx_data <= line_rx_data ^ sh[4];
				sh = sh << 1;
				nb = nb - 3'h1;
			end
		end
	end

	// ==================================================
	// Transmit check: level settles before the rise
	always @(posedge line_tx_clock) begin
		win <= {win[8:0], line_tx_data ^ tprev};
		tprev <= line_tx_data;
	end
	assign match = win == {`SYM_ESC, exp_sym};
endmodule : line_partner

//--- tb/tb_line_codec.sv
`timescale 1ns/1ps
`include "codec_cfg.svh"

module tb_line_codec;
	logic clk = 1'h0;
	logic rst_b;
	logic [3:0] tx_nibble_data = 4'h0;
	logic tx_escape_flag = 1'h0;
	logic tx_nibble_clock, line_tx_clock, line_tx_data, line_rx_clock;
	logic line_rx_data, rx_escape_flag, rx_nibble_clock, server_fail_out;
	logic symbol_sync_loss_report, pready, pslverr, irq, err, match;
	logic [3:0] rx_nibble_data;
	logic [3:0] tx_d = 4'h0;
	logic [4:0] exp_sym = 5'h00;
	logic [31:0] invalid_symbol_count, prdata, rd;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic pn = 1'h0, pr = 1'h0, chk_on = 1'h0;
	logic [4:0] expq[$];
	int fails = 0, comparisons = 0;

	always #4 clk = ~clk;

	line_codec #(.BLOCK_LEN(16)) u_dut (.clk(clk), .rst_b(rst_b),
		.tx_nibble_data(tx_nibble_data), .tx_escape_flag(tx_escape_flag),
		.tx_nibble_clock(tx_nibble_clock), .line_tx_clock(line_tx_clock),
		.line_tx_data(line_tx_data), .line_rx_clock(line_rx_clock),
		.line_rx_data(line_rx_data), .rx_nibble_data(rx_nibble_data),
		.rx_escape_flag(rx_escape_flag), .rx_nibble_clock(rx_nibble_clock),
		.server_fail_out(server_fail_out),
		.symbol_sync_loss_report(symbol_sync_loss_report),
		.invalid_symbol_count(invalid_symbol_count), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

	line_partner u_far (.clk(clk), .line_tx_clock(line_tx_clock),
		.line_tx_data(line_tx_data), .exp_sym(exp_sym), .match(match),
		.line_rx_clock(line_rx_clock), .line_rx_data(line_rx_data));

	// ==================================================
	// Helpers
	function automatic logic [4:0] sym_of(input logic [3:0] d);
		logic [79:0] t;
		t = `SYM_TABLE;
		return t[d * 5 +: 5];
	endfunction : sym_of

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) begin
			fails++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// Waits out the partner, then the decode latency
	task automatic wait_far();
		int n;
		n = 0;
		while (!u_far.idle() && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			fails++;
			test_done();
		end
		repeat (12) @(posedge clk);
	endtask : wait_far

	task automatic send(input logic [4:0] s, input logic [4:0] e);
		u_far.send(s);
		expq.push_back(e);
	endtask : send

	// ==================================================
	// Nibble side: escape and data alternate
	always @(posedge clk) begin
		pn <= tx_nibble_clock;
		pr <= rx_nibble_clock;
		if (tx_nibble_clock && !pn) begin
			tx_escape_flag <= !tx_escape_flag;
			tx_nibble_data <= tx_d;
		end
		if (rx_nibble_clock && !pr && chk_on) begin
			if (expq.size() != 0)
				chk({rx_escape_flag, rx_nibble_data}, expq.pop_front(), "rx");
			else
				chk(32'h1, 32'h0, "unexpected rx symbol");
		end
	end

	// ==================================================
	// Main sequence
	initial begin
		logic [3:0] d;
		int n;
		void'($urandom(32'hF958DA90));
		// A real falling edge, so the async reset acts before any tick
		rst_b <= 1'h0;
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		apb(1'h0, `REG_CTRL, 32'h0);
		chk(rd, 32'h1, "ctrl reset");
		apb(1'h0, `REG_MASK, 32'h0);
		chk(rd, 32'h0, "mask reset");
		apb(1'h1, 8'h20, 32'hFFFFFFFF);
		chk(err, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			d = i == 0 ? 4'h0 : i == 1 ? 4'hF : 4'($urandom);
			tx_d <= d;
			exp_sym <= sym_of(d);
			n = 0;
			@(posedge clk);
			while (match !== 1'h1 && n < 400) begin
				@(posedge clk);
				n++;
			end
			chk(match, 32'h1, "tx symbol");
			if (n >= 400)
				test_done();
		end
		$display("test transmit done");
		apb(1'h1, `REG_MASK, 32'h4);
		chk_on <= 1'h1;
		send(`SYM_ESC, 5'h10);
		for (int i = 0; i < 20; i++) begin
			d = i < 16 ? i[3:0] : 4'($urandom);
			if (i == 16)
				send(5'h00, 5'h00);
			else
				send(sym_of(d), {1'h0, d});
		end
		wait_far();
		chk(expq.size(), 32'h0, "rx missing");
		chk(invalid_symbol_count, 32'h1, "count");
		chk(symbol_sync_loss_report, 32'h0, "single invalid");
		chk(irq, 32'h1, "irq");
		apb(1'h0, `REG_EVENT, 32'h0);
		chk(rd, 32'h4, "event");
		apb(1'h1, `REG_EVENT, 32'h4);
		apb(1'h0, `REG_EVENT, 32'h0);
		chk(rd, 32'h0, "event clear");
		chk(irq, 32'h0, "irq clear");
		$display("test receive done");
		chk_on <= 1'h0;
		apb(1'h1, `REG_MASK, 32'h0);
		u_far.send(5'h00);
		u_far.send(5'h1F);
		wait_far();
		chk(server_fail_out, 32'h1, "fail out");
		chk(symbol_sync_loss_report, 32'h1, "report");
		apb(1'h0, `REG_STATUS, 32'h0);
		chk(rd, 32'h5, "status");
		apb(1'h0, `REG_EVENT, 32'h0);
		chk(rd, 32'h5, "event raise");
		chk(irq, 32'h0, "masked irq");
		apb(1'h0, `REG_COUNT, 32'h0);
		chk(rd, 32'h3, "count reg");
		$display("test defect done");
		chk_on <= 1'h1;
		send(`SYM_ESC, 5'h10);
		for (int i = 0; i < 44; i++) begin
			d = 4'($urandom);
			if (i == 20)
				send(5'h00, 5'h00);
			else
				send(sym_of(d), {1'h0, d});
		end
		wait_far();
		chk(expq.size(), 32'h0, "rehunt");
		chk(server_fail_out, 32'h0, "fail clear");
		chk(symbol_sync_loss_report, 32'h0, "report clear");
		chk(invalid_symbol_count, 32'h4, "count");
		apb(1'h0, `REG_EVENT, 32'h0);
		chk(rd, 32'h7, "event cleared");
		$display("test recovery done");
		apb(1'h0, `REG_STATUS, 32'h0);
		chk(rd, 32'h2, "locked");
		apb(1'h1, `REG_CTRL, 32'h2);
		apb(1'h0, `REG_STATUS, 32'h0);
		chk(rd, 32'h0, "realign");
		apb(1'h0, `REG_CTRL, 32'h0);
		chk(rd, 32'h0, "tx disabled");
		// Disabled transmitter must hold the line level
		d = {3'h0, line_tx_data};
		n = 0;
		repeat (200) begin
			@(posedge clk);
			if (line_tx_data !== d[0])
				n++;
		end
		chk(n, 32'h0, "frozen line");
		apb(1'h1, `REG_CTRL, 32'h1);
		apb(1'h0, `REG_CTRL, 32'h0);
		chk(rd, 32'h1, "tx enabled");
		$display("test control done");
		test_done();
	end
endmodule : tb_line_codec

//--- verilog/codec_cfg.svh
`ifndef CODEC_CFG_SVH
`define CODEC_CFG_SVH

// ==================================================
// Clock and line rates
`define CLK_MHZ 125
`define BIT_MHZ 32
`define ACC_W 8
`define ACC_STEP (2 * `BIT_MHZ)
`define ACC_MOD `CLK_MHZ

// ==================================================
// Symbol framing
`define SYM_LAST 3'h4
`define NIB_CLK_HI 3'h2
`define NIB_VALUES 16
`define SYM_ESC 5'h11
`define SYM_TABLE {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, \
	5'h12, 5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E}

// ==================================================
// Sync-loss monitor
`define BLOCK_SYMBOLS (1 << 16)
`define BLK_CNT_W 17
`define BAD_LIMIT 2'h1
`define BAD_MAX 2'h2
`define CNT_W 32

// ==================================================
// Register map
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_EVENT 8'h08
`define REG_MASK 8'h0C
`define REG_COUNT 8'h10
`define CTRL_TX_EN 0
`define CTRL_REALIGN 1
`define CTRL_RST 1'h1
`define ST_DEFECT 0
`define ST_LOCKED 1
`define ST_SSF 2
`define EV_RAISE 0
`define EV_CLEAR 1
`define EV_INVALID 2
`define EV_W 3

`endif

//--- verilog/codec_pkg.sv
`include "codec_cfg.svh"

package codec_pkg;
	typedef enum logic [1:0] {HUNT = 2'b01, LOCK = 2'b10} align_t;

	typedef struct packed {
		logic valid;
		logic invalid;
	} sym_evt_t;

	typedef struct packed {
		logic ok;
		logic esc;
		logic [3:0] nib;
	} code_t;

	typedef struct packed {
		logic defect;
		logic report;
		logic server_fail;
		logic [`CNT_W-1:0] count;
	} mon_out_t;

	typedef struct packed {
		logic [`BLK_CNT_W-1:0] blk_cnt;
		logic [1:0] bad;
		mon_out_t o;
	} mon_state_t;

	typedef struct packed {
		logic [2:0] rxc;
		logic [1:0] rxd;
		logic [`ACC_W-1:0] acc;
		logic tclk;
		logic [2:0] tslot;
		logic [4:0] tshift;
		logic tlevel;
		logic tnclk;
		logic rprev;
		logic [4:0] rwin;
		logic [2:0] rslot;
		align_t align;
		logic [3:0] rnib;
		logic resc;
		logic rnclk;
		logic sym_valid;
		logic sym_invalid;
		logic dprev;
		logic tx_en;
		logic [`EV_W-1:0] ev;
		logic [`EV_W-1:0] mask;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} top_state_t;
endpackage : codec_pkg

//--- verilog/line_codec.sv
`timescale 1ns/1ps
`include "codec_cfg.svh"

// Operation
// - Encode nibble or escape into one symbol
// - NRZI-code serial symbol bits on transmit
// - Five line bits per nibble period
// - Undo NRZI before hunting symbol boundaries
// - Find and hold five-bit symbol alignment
// - Decode symbol to nibble or escape
// - Raise defect on two invalids per block
// - Clear defect after block with at most one invalid
// - Count every invalid received symbol
module line_codec #(
	parameter int BLOCK_LEN = `BLOCK_SYMBOLS
) (
	input wire logic clk, // System clock
	input wire logic rst_b, // Asynchronous reset
	input wire logic [3:0] tx_nibble_data, // Nibble to send
	input wire logic tx_escape_flag, // Send escape
	output logic tx_nibble_clock, // Nibble rate strobe
	output logic line_tx_clock, // Transmit bit clock
	output logic line_tx_data, // Transmit line bit
	input wire logic line_rx_clock, // Receive bit clock
	input wire logic line_rx_data, // Receive line bit
	output logic [3:0] rx_nibble_data, // Received nibble
	output logic rx_escape_flag, // Received escape
	output logic rx_nibble_clock, // Received nibble clock
	output logic server_fail_out, // Server fail
	output logic symbol_sync_loss_report, // Defect report
	output logic [`CNT_W-1:0] invalid_symbol_count, // Invalid count
	input wire logic [`ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic irq // Interrupt
);
	logic [1:0] rsync;
	logic srst_b;
	codec_pkg::top_state_t s;
	codec_pkg::top_state_t next_s;
	codec_pkg::mon_out_t mon;
	codec_pkg::sym_evt_t evt;
	codec_pkg::code_t code;
	logic [`ACC_W:0] acc_sum;
	logic tx_bit;
	logic dbit;
	logic [4:0] win;
	logic rx_edge;
	logic sym_done;
	logic setup;
	logic access;
	logic wr;
	logic unmapped;
	logic realign;
	logic drise;
	logic dfall;
	logic [`EV_W-1:0] ev_set;
	logic [`EV_W-1:0] ev_clr;
	logic [31:0] rd_word;

	// ==================================================
	// Symbol table helpers
	function automatic logic [4:0] enc(input logic [3:0] n,
		input logic x);
		logic [79:0] t;
		t = `SYM_TABLE;
		enc = x ? `SYM_ESC : t[n * 5 +: 5];
	endfunction : enc

	function automatic codec_pkg::code_t dec(input logic [4:0] sym);
		logic [79:0] t;
		codec_pkg::code_t r;
		t = `SYM_TABLE;
		r = '0;
		if (sym == `SYM_ESC) begin
			r.ok = 1'b1;
			r.esc = 1'b1;
		end
		for (int i = 0; i < `NIB_VALUES; i++) begin
			if (t[i * 5 +: 5] == sym) begin
				r.ok = 1'b1;
				r.nib = 4'(i);
			end
		end
		dec = r;
	endfunction : dec

	// ==================================================
	// Reset release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rsync <= '0;
		end else begin
			rsync <= {rsync[0], 1'b1};
		end
	end

	assign srst_b = rsync[1];

	// ==================================================
	// Sync-loss monitor
	assign evt = '{valid: s.sym_valid, invalid: s.sym_invalid};

	sync_loss_monitor #(
		.BLOCK_LEN(BLOCK_LEN)
	) u_mon (
		.clk(clk),
		.srst_b(srst_b),
		.evt(evt),
		.st(mon)
	);

	// ==================================================
	// Next state
	always_comb begin
		next_s = s;
		acc_sum = '0;
		tx_bit = 1'b0;
		dbit = 1'b0;
		win = '0;
		rx_edge = 1'b0;
		sym_done = 1'b0;
		code = '0;
		setup = 1'b0;
		access = 1'b0;
		wr = 1'b0;
		unmapped = 1'b0;
		realign = 1'b0;
		ev_set = '0;
		ev_clr = '0;
		rd_word = '0;

		// Pin inputs cross through two flops first
		next_s.rxc = {s.rxc[1:0], line_rx_clock};
		next_s.rxd = {s.rxd[0], line_rx_data};
		next_s.sym_valid = 1'b0;
		next_s.sym_invalid = 1'b0;

		// Fractional divider: 32 MHz from 125 MHz, one cycle jitter
		acc_sum = {1'b0, s.acc} + (`ACC_W + 1)'(`ACC_STEP);
		if (acc_sum >= (`ACC_W + 1)'(`ACC_MOD)) begin
			next_s.acc = `ACC_W'(acc_sum - (`ACC_W + 1)'(`ACC_MOD));
			next_s.tclk = ~s.tclk;
			tx_bit = s.tclk;
		end else begin
			next_s.acc = acc_sum[`ACC_W-1:0];
		end

		// Bit boundary on the falling line clock
		if (tx_bit) begin
			if (s.tslot == `SYM_LAST) begin
				next_s.tslot = '0;
				next_s.tshift = enc(tx_nibble_data, tx_escape_flag);
				next_s.tnclk = 1'b0;
			end else begin
				next_s.tslot = s.tslot + 1'b1;
				next_s.tshift = {s.tshift[3:0], 1'b0};
				if (s.tslot + 1'b1 == `NIB_CLK_HI) begin
					next_s.tnclk = 1'b1;
				end
			end
			// Disabled transmitter holds the line level
			if (next_s.tshift[4] && s.tx_en) begin
				next_s.tlevel = ~s.tlevel;
			end
		end

		// Receive bit: decode NRZI, then look for boundaries
		rx_edge = s.rxc[1] & ~s.rxc[2];
		dbit = s.rxd[1] ^ s.rprev;
		win = {s.rwin[3:0], dbit};
		if (rx_edge) begin
			next_s.rprev = s.rxd[1];
			next_s.rwin = win;
			sym_done = (s.rslot == `SYM_LAST);
			case (s.align)
				codec_pkg::HUNT: begin
					if (win == `SYM_ESC) begin
						next_s.align = codec_pkg::LOCK;
						sym_done = 1'b1;
					end
				end
				codec_pkg::LOCK: begin
					next_s.align = codec_pkg::LOCK;
				end
				default: begin
					next_s.align = codec_pkg::HUNT;
				end
			endcase
			if (sym_done) begin
				next_s.rslot = '0;
				code = dec(win);
				next_s.sym_valid = 1'b1;
				next_s.sym_invalid = ~code.ok;
				next_s.rnib = code.nib;
				next_s.resc = code.esc;
				next_s.rnclk = 1'b1;
			end else begin
				next_s.rslot = s.rslot + 1'b1;
				if (s.rslot == `NIB_CLK_HI) begin
					next_s.rnclk = 1'b0;
				end
			end
		end

		// Defect edges feed events; a rising defect forces a new hunt
		drise = mon.defect & ~s.dprev;
		dfall = ~mon.defect & s.dprev;
		next_s.dprev = mon.defect;
		ev_set[`EV_RAISE] = drise;
		ev_set[`EV_CLEAR] = dfall;
		ev_set[`EV_INVALID] = s.sym_valid & s.sym_invalid;

		// APB slave, one wait-free access phase
		setup = psel & ~penable;
		access = psel & penable & s.pready;
		case (paddr)
			`REG_CTRL: begin
				rd_word[`CTRL_TX_EN] = s.tx_en;
			end
			`REG_STATUS: begin
				rd_word[`ST_DEFECT] = mon.defect;
				rd_word[`ST_LOCKED] = (s.align == codec_pkg::LOCK);
				rd_word[`ST_SSF] = mon.server_fail;
			end
			`REG_EVENT: begin
				rd_word[`EV_W-1:0] = s.ev;
			end
			`REG_MASK: begin
				rd_word[`EV_W-1:0] = s.mask;
			end
			`REG_COUNT: begin
				rd_word = mon.count;
			end
			default: begin
				unmapped = 1'b1;
			end
		endcase
		next_s.pready = setup;
		next_s.pslverr = setup & unmapped;
		if (setup) begin
			next_s.prdata = rd_word;
		end
		wr = access & pwrite & ~s.pslverr;
		if (wr) begin
			case (paddr)
				`REG_CTRL: begin
					next_s.tx_en = pwdata[`CTRL_TX_EN];
					realign = pwdata[`CTRL_REALIGN];
				end
				`REG_EVENT: begin
					ev_clr = pwdata[`EV_W-1:0];
				end
				`REG_MASK: begin
					next_s.mask = pwdata[`EV_W-1:0];
				end
				default: begin
					realign = 1'b0;
				end
			endcase
		end
		if (realign || drise) begin
			next_s.align = codec_pkg::HUNT;
		end

		// A new event beats a same-cycle clear
		next_s.ev = (s.ev & ~ev_clr) | ev_set;
		next_s.irq = |(next_s.ev & next_s.mask);
	end

	always_ff @(posedge clk or negedge srst_b) begin
		if (!srst_b) begin
			s <= '0;
			s.align <= codec_pkg::HUNT;
			s.tx_en <= `CTRL_RST;
		end else begin
			s <= next_s;
		end
	end

	// ==================================================
	// Outputs
	assign tx_nibble_clock = s.tnclk;
	assign line_tx_clock = s.tclk;
	assign line_tx_data = s.tlevel;
	assign rx_nibble_data = s.rnib;
	assign rx_escape_flag = s.resc;
	assign rx_nibble_clock = s.rnclk;
	assign server_fail_out = mon.server_fail;
	assign symbol_sync_loss_report = mon.report;
	assign invalid_symbol_count = mon.count;
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign irq = s.irq;

	// ==================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!srst_b);

	AST_TX_LOAD: assert property (
		$fell(s.tnclk) |->
		s.tshift == enc($past(tx_nibble_data), $past(tx_escape_flag)))
		else $error("transmit symbol does not match nibble");
	AST_TX_NRZI: assert property (
		tx_bit && s.tx_en && next_s.tshift[4] |=>
		s.tlevel != $past(s.tlevel))
		else $error("line level did not toggle on a one");
	AST_TX_QUIET: assert property (
		!tx_bit |=> $stable(s.tlevel))
		else $error("line level moved between bit boundaries");
	AST_NIB_RATE: assert property (
		$fell(s.tnclk) |-> $past(s.tslot) == `SYM_LAST)
		else $error("nibble period is not five bits");
	AST_RX_NRZI: assert property (
		rx_edge |=> s.rwin[0] == ($past(s.rxd[1]) ^ $past(s.rprev)))
		else $error("receive bit not NRZI decoded");
	AST_ALIGN: assert property (
		rx_edge && s.align == codec_pkg::HUNT && win == `SYM_ESC
		&& !realign && !drise |=>
		s.align == codec_pkg::LOCK && s.rslot == '0 && s.sym_valid)
		else $error("alignment not taken on escape");
	AST_DECODE: assert property (
		s.sym_valid && !s.sym_invalid |->
		enc(s.rnib, s.resc) == s.rwin)
		else $error("decoded nibble does not match symbol");
	AST_APB: assert property (
		setup |=> s.pready ##1 !s.pready || (psel && !penable))
		else $error("APB answer not one cycle after setup");
	AST_IRQ: assert property (
		s.irq == |(s.ev & s.mask))
		else $error("interrupt level disagrees with events");
	CVR_LOCK: cover property ($rose(s.align == codec_pkg::LOCK));
	CVR_ESC: cover property (s.sym_valid && s.resc);
	CVR_IRQ: cover property ($rose(s.irq));
endmodule : line_codec

//--- verilog/sync_loss_monitor.sv
`timescale 1ns/1ps
`include "codec_cfg.svh"

module sync_loss_monitor #(
	parameter int BLOCK_LEN = `BLOCK_SYMBOLS
) (
	input wire logic clk, // System clock
	input wire logic srst_b, // Synchronised reset
	input codec_pkg::sym_evt_t evt, // Symbol event
	output codec_pkg::mon_out_t st // Defect and counter
);
	codec_pkg::mon_state_t s;
	codec_pkg::mon_state_t next_s;
	logic [1:0] bad_now;
	logic blk_end;

	// ==================================================
	// Block bookkeeping
	always_comb begin
		next_s = s;
		bad_now = s.bad;
		blk_end = 1'b0;
		if (evt.valid) begin
			if (evt.invalid) begin
				next_s.o.count = s.o.count + 1'b1;
				// Saturate: only "more than one" matters
				if (s.bad != `BAD_MAX) begin
					bad_now = s.bad + 1'b1;
				end
			end
			blk_end = (s.blk_cnt == `BLK_CNT_W'(BLOCK_LEN - 1));
			if (blk_end) begin
				next_s.blk_cnt = '0;
				next_s.bad = '0;
			end else begin
				next_s.blk_cnt = s.blk_cnt + 1'b1;
				next_s.bad = bad_now;
			end
			if (bad_now > `BAD_LIMIT) begin
				next_s.o.defect = 1'b1;
			end else if (blk_end) begin
				next_s.o.defect = 1'b0;
			end
		end
		next_s.o.report = next_s.o.defect;
		next_s.o.server_fail = next_s.o.defect;
	end

	always_ff @(posedge clk or negedge srst_b) begin
		if (!srst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign st = s.o;

	// ==================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!srst_b);

	AST_RAISE: assert property (
		evt.valid && evt.invalid && s.bad == `BAD_LIMIT |=> st.defect)
		else $error("defect not raised on second invalid symbol");
	AST_HOLD: assert property (
		st.defect && !(evt.valid && blk_end) |=> st.defect)
		else $error("defect cleared outside block end");
	AST_CLEAR: assert property (
		evt.valid && blk_end && bad_now <= `BAD_LIMIT |=> !st.defect)
		else $error("defect kept after clean block");
	AST_COUNT: assert property (
		evt.valid && evt.invalid |=> st.count == $past(st.count) + 1)
		else $error("invalid symbol counter did not advance");
	AST_SSF: assert property (
		$rose(st.defect) |-> st.server_fail && st.report)
		else $error("server fail or report not following defect");
	CVR_RAISE: cover property ($rose(st.defect));
	CVR_CLEAR: cover property ($fell(st.defect));
endmodule : sync_loss_monitor
